// File: src/reset_source_controller.sv
// Reset source controller: brown-out, fault codes, flash and watchdog
//
// Summary of operation
// - Power-on starts at address zero, ports input
// - Brown-out always on in fast/slow modes
// - Brown-out detection off in sleep/idle
// - Short low-supply episodes never cause reset
// - Width codes give 8/32/64/128 oscillator periods
// - Five codes plus power-on value are valid
// - Bad code: delayed reset, restore, fault flag
// - Threshold select powers up as 0x66
// - Brown-out keeps threshold select, sets flag
// - Brown-out flag set by hardware, software clears
// - Select fault flag set by hardware, software clears
// - Writing 0x55 to flash control resets device
// - Watchdog timeout awake: full reset, timeout flag
// - Watchdog timeout asleep: clear PC/SP, set flags
// - Bad watchdog enable code: delayed reset, flag
// - Power-on clears timeout/power-down, brown-out keeps
`timescale 1ns/1ps
module reset_source_controller
    import rst_src_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire reg_req_t          bus_req,
    output logic [DATA_W-1:0]      bus_rdata,
    input  wire logic              supply_low,
    input  wire logic              sleep_mode,
    input  wire logic              wdt_timeout,
    output logic                   full_reset,
    output logic                   pc_sp_clear,
    output logic [11:0]            reset_vector,
    output logic [7:0]             port_data_init,
    output logic [7:0]             port_dir_init,
    output logic                   wdt_enabled,
    output logic                   irq
);
    logic [7:0]      thresh_sel_reg;
    logic [1:0]      width_sel_reg;
    logic [2:0]      cause_reg;
    logic [4:0]      wdt_field_reg;
    logic [1:0]      status_reg;
    logic [EV_N-1:0] irq_stat_reg;
    logic [EV_N-1:0] irq_mask_reg;
    rst_state_t      state_reg;
    logic            low_meta_reg;
    logic            low_sync_reg;
    logic            tick;
    logic            bo_fire;
    logic            sel_fire;
    logic            wdt_fire;
    logic            flash_hit;
    logic            to_full;
    logic            to_sleep;
    logic            any_full;
    logic [EV_N-1:0] ev;
    logic            wr_thresh;
    logic            wr_width;
    logic            wr_cause;
    logic            wr_wdt;
    logic            wr_stat;
    logic            wr_mask;

    function automatic logic thresh_valid(input logic [7:0] code);
        thresh_valid = (code == THRESH_OK_A) || (code == THRESH_OK_B) ||
                       (code == THRESH_OK_C) || (code == THRESH_OK_D) ||
                       (code == THRESH_OK_E) || (code == THRESH_POR);
    endfunction : thresh_valid

    function automatic logic [7:0] width_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    width_limit = WIDTH_T0;
            2'h1:    width_limit = WIDTH_T1;
            2'h2:    width_limit = WIDTH_T2;
            default: width_limit = WIDTH_T3;
        endcase
    endfunction : width_limit

    function automatic logic hit(input reg_req_t r, input logic [3:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    // Supply comparator is asynchronous to clk
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_meta_reg <= 1'b0;
            low_sync_reg <= 1'b0;
        end else begin
            low_meta_reg <= supply_low;
            low_sync_reg <= low_meta_reg;
        end
    end

    slow_tick u_tick (
        .clk  (clk),
        .rstn (rstn),
        .tick (tick)
    );

    // Detector active only while awake, no enable bit exists
    persist_filter u_bo_filter (
        .clk    (clk),
        .rstn   (rstn),
        .tick   (tick),
        .active (low_sync_reg && !sleep_mode && !full_reset),
        .limit  (width_limit(width_sel_reg)),
        .fire   (bo_fire)
    );

    persist_filter u_sel_delay (
        .clk    (clk),
        .rstn   (rstn),
        .tick   (tick),
        .active (!thresh_valid(thresh_sel_reg)),
        .limit  (8'(SRESET_TICKS)),
        .fire   (sel_fire)
    );

    persist_filter u_wdt_delay (
        .clk    (clk),
        .rstn   (rstn),
        .tick   (tick),
        .active (wdt_field_reg != WDT_ENABLE &&
                 wdt_field_reg != WDT_DISABLE),
        .limit  (8'(SRESET_TICKS)),
        .fire   (wdt_fire)
    );

    assign wr_thresh = hit(bus_req, OFS_THRESH_SEL);
    assign wr_width  = hit(bus_req, OFS_WIDTH_SEL);
    assign wr_cause  = hit(bus_req, OFS_CAUSE);
    assign wr_wdt    = hit(bus_req, OFS_WDT_CTRL);
    assign wr_stat   = hit(bus_req, OFS_IRQ_STAT);
    assign wr_mask   = hit(bus_req, OFS_IRQ_MASK);
    assign flash_hit = hit(bus_req, OFS_FLASH_CTL1) &&
                       bus_req.wdata == FLASH_TRIGGER;
    assign to_full   = wdt_timeout && !sleep_mode;
    assign to_sleep  = wdt_timeout && sleep_mode;
    assign any_full  = bo_fire || sel_fire || wdt_fire || flash_hit ||
                       to_full;

    assign ev[EV_BROWNOUT]  = bo_fire;
    assign ev[EV_SEL_FAULT] = sel_fire;
    assign ev[EV_WDT_FAULT] = wdt_fire;
    assign ev[EV_FLASH]     = flash_hit;
    assign ev[EV_TIMEOUT]   = wdt_timeout;

    // Threshold select: a brown-out leaves it alone
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            thresh_sel_reg <= THRESH_POR;
        end else if (sel_fire || to_full) begin
            thresh_sel_reg <= THRESH_POR;
        end else if (wr_thresh) begin
            thresh_sel_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            width_sel_reg <= WIDTH_SEL_POR;
        end else if (wr_width) begin
            width_sel_reg <= bus_req.wdata[1:0];
        end
    end

    // Watchdog enable field returns to enable on a field fault or an awake timeout, not on a sleep timeout
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdt_field_reg <= WDT_ENABLE;
        end else if (wdt_fire || to_full) begin
            wdt_field_reg <= WDT_ENABLE;
        end else if (wr_wdt) begin
            wdt_field_reg <= bus_req.wdata[7:3];
        end
    end

    // Cause flags: software may only clear, a hardware set wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cause_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_cause && !bus_req.wdata[i]) begin
                    cause_reg[i] <= 1'b0;
                end
            end
            if (bo_fire) begin
                cause_reg[CF_BROWNOUT] <= 1'b1;
            end
            if (sel_fire) begin
                cause_reg[CF_SEL_FAULT] <= 1'b1;
            end
            if (wdt_fire) begin
                cause_reg[CF_WDT_FAULT] <= 1'b1;
            end
        end
    end

    // Timeout and power-down flags: only power-on clears them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_reg <= 2'h0;
        end else if (to_sleep) begin
            status_reg[ST_TO]  <= 1'b1;
            status_reg[ST_PWR_DOWN] <= 1'b1;
        end else if (to_full) begin
            status_reg[ST_TO]  <= 1'b1;
        end
    end

    // Reset sequencing; full reset wins over a sleep timeout
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= RS_RUN;
        end else begin
            case (state_reg)
                RS_RUN: begin
                    if (any_full) begin
                        state_reg <= RS_FULL;
                    end else if (to_sleep) begin
                        state_reg <= RS_PCSP;
                    end
                end
                RS_FULL: state_reg <= RS_RUN;
                RS_PCSP: state_reg <= RS_RUN;
                default: state_reg <= RS_RUN;
            endcase
        end
    end

    assign full_reset  = state_reg == RS_FULL;
    assign pc_sp_clear = state_reg == RS_PCSP || full_reset;

    // Boot state: vector zero and all port bits high as inputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reset_vector   <= RESET_VECTOR;
            port_data_init <= PORT_POR;
            port_dir_init  <= PORT_POR;
        end else begin
            reset_vector   <= RESET_VECTOR;
            port_data_init <= PORT_POR;
            port_dir_init  <= PORT_POR;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdt_enabled <= 1'b1;
        end else begin
            wdt_enabled <= wdt_field_reg == WDT_ENABLE;
        end
    end

    // Interrupt status: write one to clear, a new event wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_reg <= '0;
        end else begin
            for (int i = 0; i < EV_N; i++) begin
                if (ev[i]) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if (wr_stat && bus_req.wdata[i]) begin
                    irq_stat_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_reg <= '0;
        end else if (wr_mask) begin
            irq_mask_reg <= bus_req.wdata[EV_N-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= '0;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_THRESH_SEL: bus_rdata <= thresh_sel_reg;
                OFS_WIDTH_SEL:  bus_rdata <= {6'h00, width_sel_reg};
                OFS_CAUSE:      bus_rdata <= {5'h00, cause_reg};
                OFS_WDT_CTRL:   bus_rdata <= {wdt_field_reg, 3'h0};
                OFS_STATUS:     bus_rdata <= {6'h00, status_reg};
                OFS_IRQ_STAT:   bus_rdata <= {3'h0, irq_stat_reg};
                OFS_IRQ_MASK:   bus_rdata <= {3'h0, irq_mask_reg};
                default:        bus_rdata <= '0;
            endcase
        end else begin
            bus_rdata <= '0;
        end
    end
endmodule : reset_source_controller

// File: src/rst_src_pkg.sv
// Shared constants and types for the reset source controller
package rst_src_pkg;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int OSC_PERIOD_NS  = 31250;
    localparam int OSC_DIV        = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int SRESET_TICKS   = 4;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    localparam logic [3:0] OFS_THRESH_SEL = 4'h0;
    localparam logic [3:0] OFS_WIDTH_SEL  = 4'h1;
    localparam logic [3:0] OFS_CAUSE      = 4'h2;
    localparam logic [3:0] OFS_WDT_CTRL   = 4'h3;
    localparam logic [3:0] OFS_FLASH_CTL1 = 4'h4;
    localparam logic [3:0] OFS_STATUS     = 4'h5;
    localparam logic [3:0] OFS_IRQ_STAT   = 4'h6;
    localparam logic [3:0] OFS_IRQ_MASK   = 4'h7;

    localparam logic [7:0] THRESH_POR    = 8'h66;
    localparam logic [7:0] THRESH_OK_A   = 8'h55;
    localparam logic [7:0] THRESH_OK_B   = 8'h33;
    localparam logic [7:0] THRESH_OK_C   = 8'h99;
    localparam logic [7:0] THRESH_OK_D   = 8'hAA;
    localparam logic [7:0] THRESH_OK_E   = 8'hF0;
    localparam logic [1:0] WIDTH_SEL_POR = 2'h1;
    localparam logic [4:0] WDT_DISABLE   = 5'h15;
    localparam logic [4:0] WDT_ENABLE    = 5'h0A;
    localparam logic [7:0] FLASH_TRIGGER = 8'h55;
    localparam logic [7:0] PORT_POR      = 8'hFF;
    localparam logic [11:0] RESET_VECTOR = 12'h000;

    localparam logic [7:0] WIDTH_T0 = 8'h08;
    localparam logic [7:0] WIDTH_T1 = 8'h20;
    localparam logic [7:0] WIDTH_T2 = 8'h40;
    localparam logic [7:0] WIDTH_T3 = 8'h80;

    // Cause flag bit positions
    localparam int CF_WDT_FAULT = 0;
    localparam int CF_SEL_FAULT = 1;
    localparam int CF_BROWNOUT  = 2;
    // Status bit positions
    localparam int ST_PWR_DOWN = 0;
    localparam int ST_TO  = 1;
    // Interrupt event bit positions
    localparam int EV_BROWNOUT  = 0;
    localparam int EV_SEL_FAULT = 1;
    localparam int EV_WDT_FAULT = 2;
    localparam int EV_FLASH     = 3;
    localparam int EV_TIMEOUT   = 4;
    localparam int EV_N         = 5;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef enum logic [2:0] {
        RS_RUN   = 3'b001,
        RS_FULL  = 3'b010,
        RS_PCSP  = 3'b100
    } rst_state_t;
endpackage : rst_src_pkg

// File: src/low_speed_oscillator_tick.sv
// Divider making the low-speed oscillator tick enable
`timescale 1ns/1ps
module slow_tick
    import rst_src_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    output logic      tick
);
    logic [11:0] cnt_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 12'h000;
            tick    <= 1'b0;
        end else if (cnt_reg == 12'(OSC_DIV - 1)) begin
            cnt_reg <= 12'h000;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 12'h001;
            tick    <= 1'b0;
        end
    end
endmodule : slow_tick

// File: src/persist_filter.sv
// Counts ticks while a condition persists and pulses at the limit
`timescale 1ns/1ps
module persist_filter
    import rst_src_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       tick,
    input  wire logic       active,
    input  wire logic [7:0] limit,
    output logic            fire
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    assign cnt_next = cnt_reg + 8'h01;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 8'h00;
            fire    <= 1'b0;
        end else if (!active) begin
            cnt_reg <= 8'h00;
            fire    <= 1'b0;
        end else if (tick && cnt_next >= limit) begin
            cnt_reg <= 8'h00;
            fire    <= 1'b1;
        end else begin
            if (tick) begin
                cnt_reg <= cnt_next;
            end
            fire <= 1'b0;
        end
    end
endmodule : persist_filter

// File: sim/reset_source_controller_chk.sv
// Port assertions for the reset source controller
`timescale 1ns/1ps
module reset_source_controller_chk
    import rst_src_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire reg_req_t    bus_req,
    input wire logic        sleep_mode,
    input wire logic        wdt_timeout,
    input wire logic        full_reset,
    input wire logic        pc_sp_clear,
    input wire logic [11:0] reset_vector,
    input wire logic [7:0]  port_data_init,
    input wire logic [7:0]  port_dir_init,
    input wire logic        wdt_enabled,
    input wire logic        irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic       flash_hit;
    logic       wdt_wr;
    logic [4:0] fld;
    assign flash_hit = bus_req.wr && bus_req.addr == OFS_FLASH_CTL1
                       && bus_req.wdata == FLASH_TRIGGER;
    assign wdt_wr    = bus_req.wr && bus_req.addr == OFS_WDT_CTRL;
    assign fld       = bus_req.wdata[7:3];

    property p_flash; flash_hit |=> full_reset; endproperty
    a_flash: assert property (p_flash)
        else $error("flash trigger gave no reset");
    property p_wdt_run;
        wdt_timeout && !sleep_mode |=> full_reset && pc_sp_clear;
    endproperty
    a_wdt_run: assert property (p_wdt_run)
        else $error("awake timeout gave no full reset");
    property p_wdt_sleep;
        wdt_timeout && sleep_mode && !flash_hit |=> pc_sp_clear && !full_reset;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep)
        else $error("asleep timeout gave wrong reset");
    property p_pulse; full_reset |=> !full_reset; endproperty
    a_pulse: assert property (p_pulse)
        else $error("full reset longer than one cycle");
    property p_pc_with_full; full_reset |-> pc_sp_clear; endproperty
    a_pc_with_full: assert property (p_pc_with_full)
        else $error("full reset without pc clear");
    property p_init;
        reset_vector == RESET_VECTOR && port_data_init == PORT_POR
        && port_dir_init == PORT_POR;
    endproperty
    a_init: assert property (p_init)
        else $error("start address or port presets wrong");
    // Field lands one edge after the write, the registered enable one later
    property p_wdt_off;
        wdt_wr && fld == WDT_DISABLE && !wdt_timeout |-> ##2 !wdt_enabled;
    endproperty
    a_wdt_off: assert property (p_wdt_off)
        else $error("watchdog still enabled");
    property p_wdt_on;
        wdt_wr && fld == WDT_ENABLE |-> ##2 wdt_enabled;
    endproperty
    a_wdt_on: assert property (p_wdt_on)
        else $error("watchdog not enabled");
    // A bad field must hold off reset for eight cycles, never reset at once
    property p_delay;
        wdt_wr && fld != WDT_ENABLE && fld != WDT_DISABLE |=> !full_reset [*8];
    endproperty
    a_delay: assert property (p_delay)
        else $error("field fault reset came too early");

    c_full: cover property (full_reset);
    c_pcsp: cover property (pc_sp_clear && !full_reset);
    c_irq: cover property (irq);
endmodule : reset_source_controller_chk

bind reset_source_controller reset_source_controller_chk u_chk (
    .clk(clk), .rstn(rstn), .bus_req(bus_req), .sleep_mode(sleep_mode),
    .wdt_timeout(wdt_timeout), .full_reset(full_reset),
    .pc_sp_clear(pc_sp_clear), .reset_vector(reset_vector),
    .port_data_init(port_data_init), .port_dir_init(port_dir_init),
    .wdt_enabled(wdt_enabled), .irq(irq)
);

// File: sim/reset_source_controller_tb_top.sv
// Directed bench for the reset source controller
`timescale 1ns/1ps
module reset_source_controller_tb_top
    import rst_src_pkg::*;
;
    localparam int D  = OSC_DIV;
    localparam int LO = (SRESET_TICKS - 1) * D;
    localparam int HI = (SRESET_TICKS + 1) * D + 20;
    logic        clk;
    logic        rstn;
    logic        supply_low;
    logic        sleep_mode;
    logic        wdt_timeout;
    reg_req_t    req;
    logic [7:0]  bus_rdata;
    logic        full_reset;
    logic        pc_sp_clear;
    logic [11:0] reset_vector;
    logic [7:0]  port_data_init;
    logic [7:0]  port_dir_init;
    logic        wdt_enabled;
    logic        irq;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic [7:0]  ok_codes [5];

    reset_source_controller u_dut (
        .clk(clk), .rstn(rstn), .bus_req(req), .bus_rdata(bus_rdata),
        .supply_low(supply_low), .sleep_mode(sleep_mode),
        .wdt_timeout(wdt_timeout), .full_reset(full_reset),
        .pc_sp_clear(pc_sp_clear), .reset_vector(reset_vector),
        .port_data_init(port_data_init), .port_dir_init(port_dir_init),
        .wdt_enabled(wdt_enabled), .irq(irq)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic chk(input string n, input logic [11:0] s, e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e, string n);
        @(posedge clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk(n, bus_rdata, e);
    endtask : rd

    task automatic quiet(input string n, input int len);
        logic hit;
        hit = 1'b0;
        repeat (len) begin
            #1 if (full_reset === 1'b1) hit = 1'b1;
            @(posedge clk);
        end
        chk(n, hit, 1'b0);
    endtask : quiet

    task automatic fr_in(input string n, input int lo, hi);
        int k;
        k = 0;
        #1;
        while (full_reset !== 1'b1 && k < hi) begin
            @(posedge clk);
            #1 k++;
        end
        chk(n, k >= lo && full_reset === 1'b1, 1'b1);
    endtask : fr_in

    task automatic pulse_wdt(input logic s);
        @(posedge clk);
        sleep_mode  <= s;
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
    endtask : pulse_wdt

    task automatic low_for(input logic v, input int len, input string n);
        @(posedge clk);
        supply_low <= v;
        quiet(n, len);
    endtask : low_for

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Ceiling sits just above the summed oscillator waits of the sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 98000) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        ok_codes = '{THRESH_OK_A, THRESH_OK_B, THRESH_OK_C, THRESH_OK_D,
                     THRESH_OK_E};
        rstn        = 1'b0;
        supply_low  = 1'b0;
        sleep_mode  = 1'b0;
        wdt_timeout = 1'b0;
        req         = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd(OFS_THRESH_SEL, 8'h66, "thresh_por");
        rd(OFS_WIDTH_SEL, 8'h01, "width_por");
        rd(OFS_CAUSE, 8'h00, "cause_por");
        rd(OFS_STATUS, 8'h00, "status_por");
        rd(4'h8, 8'h00, "unmapped");
        chk("vector", reset_vector, 12'h000);
        chk("port_data", port_data_init, 12'h0FF);
        chk("port_dir", port_dir_init, 12'h0FF);
        wr(OFS_FLASH_CTL1, 8'h54);
        quiet("flash_other", 4);
        wr(OFS_FLASH_CTL1, 8'h55);
        fr_in("flash_reset", 0, 1);
        rd(OFS_IRQ_STAT, 8'h08, "irq_flash");
        chk("irq_masked", irq, 1'b0);
        wr(OFS_IRQ_MASK, 8'h08);
        #1 chk("irq_on", irq, 1'b1);
        wr(OFS_IRQ_STAT, 8'h08);
        #1 chk("irq_clr", irq, 1'b0);
        pulse_wdt(1'b0);
        fr_in("wdt_awake", 0, 0);
        rd(OFS_STATUS, 8'h02, "status_to");
        pulse_wdt(1'b1);
        #1 chk("pcsp", pc_sp_clear, 1'b1);
        chk("no_full", full_reset, 1'b0);
        wr(OFS_STATUS, 8'h00);
        rd(OFS_STATUS, 8'h03, "status_pdf");
        sleep_mode <= 1'b0;
        // The enable output is registered from the field: one edge later
        wr(OFS_WDT_CTRL, 8'hA8);
        @(posedge clk);
        #1 chk("wdt_off", wdt_enabled, 1'b0);
        wr(OFS_WDT_CTRL, 8'h50);
        @(posedge clk);
        #1 chk("wdt_on", wdt_enabled, 1'b1);
        wr(OFS_WDT_CTRL, 8'h00);
        fr_in("wdt_fault", LO, HI);
        rd(OFS_CAUSE, 8'h01, "cause_wdt");
        chk("wdt_back", wdt_enabled, 1'b1);
        foreach (ok_codes[i]) begin
            wr(OFS_THRESH_SEL, ok_codes[i]);
            rd(OFS_THRESH_SEL, ok_codes[i], "thresh_ok");
        end
        wr(OFS_THRESH_SEL, 8'h12);
        fr_in("thresh_fault", LO, HI);
        rd(OFS_THRESH_SEL, 8'h66, "thresh_back");
        rd(OFS_CAUSE, 8'h03, "cause_sel");
        wr(OFS_CAUSE, 8'h07);
        rd(OFS_CAUSE, 8'h03, "cause_keep");
        wr(OFS_CAUSE, 8'h00);
        rd(OFS_CAUSE, 8'h00, "cause_clr");
        for (int c = 3; c >= 0; c--) begin
            wr(OFS_WIDTH_SEL, 8'(c));
            rd(OFS_WIDTH_SEL, 8'(c), "width_sel");
        end
        wr(OFS_THRESH_SEL, 8'h55);
        // Together the two episodes pass the limit, so a kept count fires
        low_for(1'b1, D * 9 / 2, "glitch_a");
        low_for(1'b0, 10, "gap_a");
        low_for(1'b1, D * 9 / 2, "glitch_b");
        low_for(1'b0, 10, "gap_b");
        sleep_mode <= 1'b1;
        low_for(1'b1, D * 3, "asleep");
        sleep_mode <= 1'b0;
        quiet("awake", D * 6);
        fr_in("brownout", 0, D * 2 + 40);
        supply_low <= 1'b0;
        rd(OFS_THRESH_SEL, 8'h55, "thresh_kept");
        rd(OFS_CAUSE, 8'h04, "cause_bo");
        rd(OFS_STATUS, 8'h03, "status_kept");
        // Second power-on in mid-run must drop the kept flags and codes
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(OFS_STATUS, 8'h00, "status_por2");
        rd(OFS_THRESH_SEL, 8'h66, "thresh_por2");
        rd(OFS_CAUSE, 8'h00, "cause_por2");
        complete_run();
    end
endmodule : reset_source_controller_tb_top
